// [common/ipw_pkg.sv]
// package of constants for the indexed port watchdog
// Overview of operation
// - count down, reset system at zero
// - index port selects, data port transfers
// - unlock byte twice opens configuration
// - device select routes accesses to watchdog
// - activation value enables watchdog function
// - time base selects seconds or minutes
// - zero disables, N expires after N seconds
// - minutes mode expires after N minutes
// - activate zero disables watchdog anytime
// - count register accepts every byte value
package ipw_pkg;
   localparam logic       PORT_INDEX      = 1'b0;
   localparam logic       PORT_DATA       = 1'b1;
   localparam logic [7:0] UNLOCK_BYTE     = 8'h87;
   localparam logic [7:0] LOCK_BYTE       = 8'hAA;
   localparam logic [7:0] IDX_DEV_SELECT  = 8'h07;
   localparam logic [7:0] IDX_ACTIVATION  = 8'h2D;
   localparam logic [7:0] IDX_DEV_ACTIVE  = 8'h30;
   localparam logic [7:0] IDX_TIME_BASE   = 8'hF5;
   localparam logic [7:0] IDX_COUNT       = 8'hF6;
   localparam logic [7:0] WDOG_DEVICE     = 8'h08;
   localparam logic [7:0] ACTIVATION_VAL  = 8'h20;
   localparam logic [7:0] BASE_MINUTE     = 8'h08;
   localparam int         MINUTE_BIT      = 3;
   localparam int         ACTIVE_BIT      = 0;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam int         CLK_HZ          = 40000000;
   localparam int         SEC_PER_MIN     = 60;
   localparam int         RESET_PULSE_CYC = 16;
endpackage

// [common/ipw_tick_if.sv]
// interface carrying the time-base ticks
`timescale 1ns/1ps
interface ipw_tick_if;
   logic minute_mode;
   logic restart;
   logic tick;
   modport gen (input minute_mode, input restart, output tick);
   modport use_ (output minute_mode, output restart, input tick);
endinterface

// [hdl/ipw_tick_gen.sv]
// time-base generator: one tick per second or per minute
`timescale 1ns/1ps
module ipw_tick_gen #(
   parameter int CYC_PER_SEC = ipw_pkg::CLK_HZ
) (
   input  wire logic   sys_clk_i,
   input  wire logic   rst_n_i,
   ipw_tick_if.gen     tk
);
   typedef struct packed {
      logic [31:0] cyc;
      logic [5:0]  sec;
      logic        tick;
   } ipw_tick_st_t;
   ipw_tick_st_t s_q, s_d;
   assign tk.tick = s_q.tick;
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (tk.restart) begin
         s_d.cyc = '0;
         s_d.sec = '0;
      end else if (s_q.cyc == 32'(CYC_PER_SEC - 1)) begin
         s_d.cyc = '0;
         if (!tk.minute_mode) begin
            s_d.tick = 1'b1;
         end else if (s_q.sec == 6'(ipw_pkg::SEC_PER_MIN - 1)) begin
            s_d.sec = '0;
            s_d.tick = 1'b1;
         end else begin
            s_d.sec = s_q.sec + 6'h01;
         end
      end else begin
         s_d.cyc = s_q.cyc + 32'h00000001;
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// [hdl/ipw_watchdog.sv]
// indexed configuration port with system watchdog
`timescale 1ns/1ps
module ipw_watchdog #(
   parameter int CYC_PER_SEC = ipw_pkg::CLK_HZ,
   parameter int RESET_CYC   = ipw_pkg::RESET_PULSE_CYC
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic       io_addr_i,
   input  wire logic [7:0] io_wdata_i,
   output logic      [7:0] io_rdata_o,
   output logic            cfg_open_o,
   output logic            wdog_running_o,
   output logic            sys_reset_o
);
   typedef struct packed {
      logic       unlock1;
      logic       open;
      logic [7:0] index;
      logic [7:0] dev_sel;
      logic [7:0] activation;
      logic [7:0] dev_active;
      logic [7:0] time_base;
      logic [7:0] count_val;
      logic [7:0] remain;
      logic [7:0] rdata;
      logic       restart;
      logic [4:0] rst_cnt;
   } ipw_state_t;
   ipw_state_t s_q, s_d;
   ipw_tick_if tk ();
   logic wr_idx, wr_dat, rd_dat, on_wdog, running;

   function automatic logic [7:0] read_reg(input ipw_state_t s);
      read_reg = 8'h00;
      if (s.index == ipw_pkg::IDX_DEV_SELECT) begin
         read_reg = s.dev_sel;
      end else if (s.dev_sel == ipw_pkg::WDOG_DEVICE) begin
         case (s.index)
            ipw_pkg::IDX_ACTIVATION: read_reg = s.activation;
            ipw_pkg::IDX_DEV_ACTIVE: read_reg = s.dev_active;
            ipw_pkg::IDX_TIME_BASE:  read_reg = s.time_base;
            ipw_pkg::IDX_COUNT:      read_reg = s.remain;
            default:                 read_reg = 8'h00;
         endcase
      end
   endfunction

   ipw_tick_gen #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .tk        (tk)
   );

   assign wr_idx  = io_wr_i && io_addr_i == ipw_pkg::PORT_INDEX;
   assign wr_dat  = io_wr_i && io_addr_i == ipw_pkg::PORT_DATA && s_q.open;
   assign rd_dat  = io_rd_i && io_addr_i == ipw_pkg::PORT_DATA && s_q.open;
   assign on_wdog = s_q.dev_sel == ipw_pkg::WDOG_DEVICE;
   assign running = s_q.activation == ipw_pkg::ACTIVATION_VAL
                    && s_q.dev_active[ipw_pkg::ACTIVE_BIT]
                    && s_q.count_val != 8'h00;
   assign tk.minute_mode = s_q.time_base[ipw_pkg::MINUTE_BIT];
   assign tk.restart     = s_q.restart;

   always_comb begin
      s_d = s_q;
      s_d.restart = 1'b0;
      if (wr_idx) begin
         if (!s_q.open) begin
            // two back-to-back unlock writes open the space
            s_d.unlock1 = io_wdata_i == ipw_pkg::UNLOCK_BYTE;
            s_d.open    = s_q.unlock1 &&
                          io_wdata_i == ipw_pkg::UNLOCK_BYTE;
         end else if (io_wdata_i == ipw_pkg::LOCK_BYTE) begin
            s_d.open    = 1'b0;
            s_d.unlock1 = 1'b0;
         end else begin
            s_d.index = io_wdata_i;
         end
      end else if (io_wr_i || io_rd_i) begin
         s_d.unlock1 = 1'b0;
      end
      if (rd_dat) begin
         s_d.rdata = read_reg(s_q);
      end
      if (running && tk.tick && s_q.remain != 8'h00) begin
         s_d.remain = s_q.remain - 8'h01;
      end
      if (wr_dat) begin
         if (s_q.index == ipw_pkg::IDX_DEV_SELECT) begin
            s_d.dev_sel = io_wdata_i;
         end else if (on_wdog) begin
            case (s_q.index)
               ipw_pkg::IDX_ACTIVATION: s_d.activation = io_wdata_i;
               ipw_pkg::IDX_DEV_ACTIVE: begin
                  s_d.dev_active = io_wdata_i;
                  s_d.restart    = 1'b1;
                  s_d.remain     = s_q.count_val;
               end
               ipw_pkg::IDX_TIME_BASE: begin
                  s_d.time_base = io_wdata_i;
                  s_d.restart   = 1'b1;
               end
               ipw_pkg::IDX_COUNT: begin
                  s_d.count_val = io_wdata_i;
                  s_d.remain    = io_wdata_i;
                  s_d.restart   = 1'b1;
               end
               default: s_d.rst_cnt = s_q.rst_cnt;
            endcase
         end
      end
      // expiry: disarm at once and hold reset for a fixed pulse
      if (s_q.rst_cnt != 5'h00) begin
         s_d.rst_cnt = s_q.rst_cnt - 5'h01;
      end else if (running && s_q.remain == 8'h01 && tk.tick) begin
         s_d.rst_cnt    = 5'(RESET_CYC);
         s_d.dev_active = 8'h00;
         s_d.remain     = 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign io_rdata_o     = s_q.rdata;
   assign cfg_open_o     = s_q.open;
   assign wdog_running_o = running;
   assign sys_reset_o    = s_q.rst_cnt != 5'h00;
endmodule

// [verif/ipw_watchdog_assertions.sv]
// assertion checker for the indexed port watchdog
`timescale 1ns/1ps
module ipw_watchdog_assertions #(
   parameter int RESET_CYC = 16
) (
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       io_wr_i,
   input wire logic       io_rd_i,
   input wire logic       io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic       cfg_open_o,
   input wire logic       wdog_running_o,
   input wire logic       sys_reset_o
);
   logic [7:0] idx_q;
   logic [7:0] dev_q;
   int         hi_q;
   wire        dw = io_wr_i && io_addr_i && cfg_open_o;
   wire        rdd = io_rd_i && io_addr_i && cfg_open_o;
   wire        wd = dw && dev_q == 8'h08;
   // shadow of index and device select, length of reset pulse
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_q <= 8'h00;
         dev_q <= 8'h00;
         hi_q  <= 0;
      end else begin
         // the relock byte closes the space and leaves the index as it was
         if (io_wr_i && !io_addr_i && cfg_open_o && io_wdata_i != 8'hAA) begin
            idx_q <= io_wdata_i;
         end
         if (dw && idx_q == 8'h07) dev_q <= io_wdata_i;
         hi_q <= sys_reset_o ? hi_q + 1 : 0;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_open_unlock: assert property ($rose(cfg_open_o) |->
      $past(io_wr_i && !io_addr_i && io_wdata_i == 8'h87))
      else $error("space opened without unlock byte");
   a_relock_byte: assert property (io_wr_i && !io_addr_i &&
      io_wdata_i == 8'hAA |=> !cfg_open_o) else $error("relock failed");
   a_locked_stale: assert property (io_rd_i && io_addr_i &&
      !cfg_open_o |=> $stable(io_rdata_o)) else $error("locked read changed");
   a_select_read: assert property (rdd && idx_q == 8'h07
      |=> io_rdata_o == dev_q) else $error("device select readback");
   a_unmapped_zero: assert property (rdd && !(idx_q inside
      {8'h07, 8'h2D, 8'h30, 8'hF5, 8'hF6}) |=> io_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_stop_any: assert property (wd && idx_q == 8'h30 &&
      !io_wdata_i[0] |=> !wdog_running_o) else $error("disable ignored");
   a_count_off: assert property (wd && idx_q == 8'hF6 &&
      io_wdata_i == 8'h00 |=> !wdog_running_o) else $error("zero count runs");
   a_reset_cause: assert property ($rose(sys_reset_o)
      |-> $past(wdog_running_o)) else $error("reset while not running");
   a_reset_len: assert property ($fell(sys_reset_o)
      |-> hi_q == RESET_CYC) else $error("reset pulse length");
   c_open: cover property ($rose(cfg_open_o));
   c_expiry: cover property ($rose(sys_reset_o));
   c_stop: cover property ($fell(wdog_running_o) && !sys_reset_o);
endmodule
bind ipw_watchdog ipw_watchdog_assertions #(.RESET_CYC(RESET_CYC)) chk_u (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .io_wr_i(io_wr_i),
   .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
   .io_rdata_o(io_rdata_o), .cfg_open_o(cfg_open_o),
   .wdog_running_o(wdog_running_o), .sys_reset_o(sys_reset_o));

// [verif/ipw_watchdog_test.sv]
// self-checking bench for the indexed port watchdog
`timescale 1ns/1ps
module ipw_watchdog_test;
   localparam int U = 4;
   logic        sys_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        io_wr_i = 1'b0;
   logic        io_rd_i = 1'b0;
   logic        io_addr_i = 1'b0;
   logic [7:0]  io_wdata_i = 8'h00;
   logic [7:0]  io_rdata_o;
   logic [7:0]  rd_v;
   logic        cfg_open_o;
   logic        wdog_running_o;
   logic        sys_reset_o;
   logic [31:0] rnd = 32'h9E54;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          q[$];
   int          t;
   int          n;
   ipw_watchdog #(.CYC_PER_SEC(U)) dut_u (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .cfg_open_o(cfg_open_o), .wdog_running_o(wdog_running_o),
      .sys_reset_o(sys_reset_o));
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      @(negedge sys_clk_i);
      {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, a, d};
      @(negedge sys_clk_i);
      io_wr_i = 1'b0;
   endtask
   task automatic rg(input logic [7:0] i, input logic [7:0] d);
      wr(1'b0, i);
      wr(1'b1, d);
   endtask
   task automatic rd(input logic [7:0] i);
      wr(1'b0, i);
      {io_rd_i, io_addr_i} = 2'b11;
      @(negedge sys_clk_i);
      io_rd_i = 1'b0;
      rd_v = io_rdata_o;
   endtask
   // cycles from the last write until the system reset request
   task automatic expire(input int cyc);
      t = 0;
      while (sys_reset_o !== 1'b1 && t < cyc + 8) begin
         @(negedge sys_clk_i);
         t++;
      end
      chk("expiry", 8'h01, 8'(t >= cyc - 2 && t <= cyc + 2));
      if (t >= cyc + 8) print_verdict();
      repeat (20) @(negedge sys_clk_i);
      chk("disarm", 8'h00, wdog_running_o);
   endtask
   initial begin
      repeat (5) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      rg(8'h07, 8'h08);
      rd(8'h07);
      chk("locked", 8'h00, rd_v);
      wr(1'b0, 8'h87);
      wr(1'b0, 8'h87);
      chk("open", 8'h01, cfg_open_o);
      rg(8'h2D, 8'h20);
      rg(8'h30, 8'h01);
      rg(8'hF6, 8'h05);
      chk("unselected", 8'h00, wdog_running_o);
      rg(8'h07, 8'h08);
      rd(8'h07);
      chk("select", 8'h08, rd_v);
      rg(8'h30, 8'h00);
      for (n = 0; n < 6; n++) begin
         rnd = lfsr(rnd);
         q.push_back(n == 0 ? 255 : rnd[7:0]);
         rg(8'hF6, 8'(q[$]));
         rd(8'hF6);
         chk("count", 8'(q.pop_front()), rd_v);
      end
      rg(8'h2D, 8'h20);
      rg(8'h30, 8'h01);
      rg(8'hF5, 8'h00);
      rnd = lfsr(rnd);
      n = rnd[1:0] + 1;
      rg(8'hF6, 8'(n));
      chk("running", 8'h01, wdog_running_o);
      expire(n * U);
      rg(8'h30, 8'h01);
      rg(8'hF6, 8'h03);
      repeat (2 * U) @(negedge sys_clk_i);
      wr(1'b1, 8'h03);
      expire(3 * U);
      rg(8'h30, 8'h01);
      rg(8'hF5, 8'h08);
      rg(8'hF6, 8'h01);
      expire(60 * U);
      rg(8'hF5, 8'h00);
      rg(8'h30, 8'h01);
      rg(8'hF6, 8'h02);
      rg(8'h30, 8'h00);
      chk("stopped", 8'h00, wdog_running_o);
      repeat (5 * U) @(negedge sys_clk_i);
      chk("no reset", 8'h00, sys_reset_o);
      rg(8'h30, 8'h01);
      rg(8'hF6, 8'h00);
      chk("zero count", 8'h00, wdog_running_o);
      rd(8'h55);
      chk("unmapped", 8'h00, rd_v);
      wr(1'b0, 8'hAA);
      chk("relock", 8'h00, cfg_open_o);
      print_verdict();
   end
endmodule
